//--- hw/pin_io_pkg.sv
`default_nettype none
package pin_io_pkg;
	// Register indices; each word sits at four times its index
	localparam logic [7:0] DRIVE_ENABLE_IDX = 8'h44;
	localparam logic [7:0] OUTPUT_LEVEL_IDX = 8'h45;
	localparam logic [7:0] INPUT_LEVEL_IDX = 8'h46;
	// Block-own control register: scan strap and clock selector
	localparam logic [7:0] CLOCK_CTRL_IDX = 8'h48;
	// Byte addresses, one aligned word each
	localparam logic [11:0] DRIVE_ENABLE_ADDR = {2'b00, DRIVE_ENABLE_IDX, 2'b00};
	localparam logic [11:0] OUTPUT_LEVEL_ADDR = {2'b00, OUTPUT_LEVEL_IDX, 2'b00};
	localparam logic [11:0] INPUT_LEVEL_ADDR = {2'b00, INPUT_LEVEL_IDX, 2'b00};
	localparam logic [11:0] CLOCK_CTRL_ADDR = {2'b00, CLOCK_CTRL_IDX, 2'b00};
	// Field layout of the clock control register
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 4;
	localparam int SCAN_BIT = 4;
	// Selector code that leaves the clock pin as plain I/O
	localparam logic [3:0] SEL_IO_CODE = 4'h0;
	// Pin bit positions
	localparam int SIG_IN_BIT = 7;
	localparam int CLK_OUT_BIT = 6;
	localparam int SEL_UP_BIT = 5;
	localparam int SEL_LO_BIT = 4;
	localparam int TCK_BIT = 3;
	localparam int TDI_BIT = 2;
	localparam int TDO_BIT = 1;
	localparam int TMS_BIT = 0;
	// Mask of the four scan pins
	localparam logic [7:0] SCAN_MASK = 8'h0f;
	// Reset values
	localparam logic [7:0] DRIVE_RESET = 8'h00;
	localparam logic [7:0] LEVEL_RESET = 8'h00;
	localparam logic [3:0] SEL_RESET = 4'h0;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

//--- hw/reset_sync.sv
`default_nettype none
// Two-stage release of the asynchronous reset
module reset_sync (
	input wire logic core_clk,
	input wire logic nrst,
	output logic sync_nrst
);
	// First stage, read only by the second
	logic meta_r;
	// Assert at once, release after two edges
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= 1'b0;
			sync_nrst <= 1'b0;
		end else begin
			meta_r <= 1'b1;
			sync_nrst <= meta_r;
		end
	end
endmodule // reset_sync
`default_nettype wire

//--- hw/pin_io_config.sv
// How it works
// RQ1 - Enable register at 44h, eight RW bits
// RQ2 - Bit 7 drives the signal input pin
// RQ3 - Bit 6 makes clock pin I/O, clock off
// RQ4 - Bits 5,4 drive upper, lower select pins
// RQ5 - Bits 3..0 drive TCK, TDI, TDO, TMS
// RQ6 - Scan strap overrides the four scan enables
// RQ7 - Output register at 45h feeds output buffers
// RQ8 - Output bit 2 drives the TDI pin
// RQ9 - Input register at 46h returns pin levels
// RQ10 - Selector code 0 makes clock pin I/O
// RQ11 - Disabled driver still reads input level
// RQ12 - Input register writes ignored; reset to zero
//
// The implementer's own choice: the AXI4-Lite register port.
`default_nettype none
module pin_io_config
	import pin_io_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic core_clk,
	input wire logic nrst,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pin side: input level, output level, enable (low drives)
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n,
	// Scan interface drives for the scan pins when strapped
	input wire logic scan_strap,
	input wire logic [3:0] scan_out,
	input wire logic [3:0] scan_drive,
	// Clock source for the clock output pin
	input wire logic clock_source,
	// Scan-active strap level as seen by the block
	output logic scan_active
);
	// Write engine states
	typedef enum logic [2:0] {
		W_IDLE = 3'b001,
		W_HAVE = 3'b010,
		W_RESP = 3'b100
	} wstate_type;

	// All state of the block
	typedef struct packed {
		wstate_type wst;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] drive_en;
		logic [7:0] out_level;
		logic [7:0] in_level;
		logic [SEL_W-1:0] clk_sel;
		logic scan_on;
		logic [7:0] pin_out;
		logic [7:0] pin_oe_n;
	} state_type;

	// Synchronised reset
	logic rst_n;
	// Registered and next state
	state_type st_r;
	state_type st_nxt;
	// Effective enables after the strap override
	logic [7:0] eff_en;

	// Reset release
	reset_sync u_rst (
		.core_clk(core_clk),
		.nrst(nrst),
		.sync_nrst(rst_n)
	);

	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		// Pin inputs sampled each cycle
		// RQ11 input always readable
		st_nxt.in_level = pin_in;
		st_nxt.scan_on = scan_strap;
		// Write channel capture, either order
		case (st_r.wst)
			W_IDLE, W_HAVE: begin
				if (s_axi_awvalid && !st_r.aw_got) begin
					st_nxt.aw_got = 1'b1;
					st_nxt.waddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && !st_r.w_got) begin
					st_nxt.w_got = 1'b1;
					st_nxt.wdata = s_axi_wdata;
					st_nxt.wstrb = s_axi_wstrb;
				end
				st_nxt.wst = W_HAVE;
				if (st_r.aw_got && st_r.w_got) begin
					// Commit the write, byte lane 0 only
					st_nxt.bresp = RESP_OKAY;
					if (st_r.waddr == ADDR_W'(DRIVE_ENABLE_ADDR)) begin
						// RQ1 enable register write
						if (st_r.wstrb[0]) begin
							st_nxt.drive_en = st_r.wdata[7:0];
						end
					end else if (st_r.waddr == ADDR_W'(OUTPUT_LEVEL_ADDR)) begin
						// RQ7 output level write
						if (st_r.wstrb[0]) begin
							st_nxt.out_level = st_r.wdata[7:0];
						end
					end else if (st_r.waddr == ADDR_W'(INPUT_LEVEL_ADDR)) begin
						// RQ12 read-only, write dropped
						st_nxt.bresp = RESP_OKAY;
					end else if (st_r.waddr == ADDR_W'(CLOCK_CTRL_ADDR)) begin
						if (st_r.wstrb[0]) begin
							st_nxt.clk_sel = st_r.wdata[SEL_LSB +: SEL_W];
						end
					end else begin
						// Unmapped address
						st_nxt.bresp = RESP_SLVERR;
					end
					st_nxt.aw_got = 1'b0;
					st_nxt.w_got = 1'b0;
					st_nxt.wst = W_RESP;
				end
			end
			W_RESP: begin
				// Hold response until taken
				if (s_axi_bready) begin
					st_nxt.wst = W_IDLE;
				end
			end
			default: begin
				st_nxt.wst = W_IDLE;
			end
		endcase
		// Read channel
		if (st_r.rvalid) begin
			if (s_axi_rready) begin
				st_nxt.rvalid = 1'b0;
			end
		end else if (s_axi_arvalid) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			if (s_axi_araddr == ADDR_W'(DRIVE_ENABLE_ADDR)) begin
				st_nxt.rdata[7:0] = st_r.drive_en;
			end else if (s_axi_araddr == ADDR_W'(OUTPUT_LEVEL_ADDR)) begin
				st_nxt.rdata[7:0] = st_r.out_level;
			end else if (s_axi_araddr == ADDR_W'(INPUT_LEVEL_ADDR)) begin
				// RQ9 input levels
				st_nxt.rdata[7:0] = st_r.in_level;
			end else if (s_axi_araddr == ADDR_W'(CLOCK_CTRL_ADDR)) begin
				st_nxt.rdata[SEL_LSB +: SEL_W] = st_r.clk_sel;
				st_nxt.rdata[SCAN_BIT] = st_r.scan_on;
			end else begin
				st_nxt.rresp = RESP_SLVERR;
			end
		end
		// Effective enables per pin
		// RQ2 RQ4 RQ5 RQ11 bit-per-pin enables
		eff_en = st_r.drive_en;
		// RQ6 strap overrides scan enables
		if (st_r.scan_on) begin
			eff_en = eff_en & ~SCAN_MASK;
		end
		// RQ7 RQ8 output buffers follow bits
		st_nxt.pin_out = st_r.out_level;
		st_nxt.pin_oe_n = ~eff_en;
		// Scan pins under scan control when strapped
		if (st_r.scan_on) begin
			st_nxt.pin_out[3:0] = scan_out;
			st_nxt.pin_oe_n[3:0] = ~scan_drive;
		end
		// Clock pin: clock function unless enabled as I/O or code 0
		// RQ3 RQ10 clock pin as I/O
		if (!st_r.drive_en[CLK_OUT_BIT] && st_r.clk_sel != SEL_IO_CODE) begin
			st_nxt.pin_out[CLK_OUT_BIT] = clock_source;
			st_nxt.pin_oe_n[CLK_OUT_BIT] = 1'b0;
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			// RQ12 reset to zero
			st_r <= '{wst: W_IDLE, aw_got: 1'b0, w_got: 1'b0, waddr: '0,
				wdata: 32'h0000_0000, wstrb: 4'h0, bresp: RESP_OKAY,
				rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY,
				drive_en: DRIVE_RESET, out_level: LEVEL_RESET,
				in_level: 8'h00, clk_sel: SEL_RESET, scan_on: 1'b0,
				pin_out: 8'h00, pin_oe_n: 8'hff};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Bus handshakes
	assign s_axi_awready = (st_r.wst != W_RESP) && !st_r.aw_got;
	assign s_axi_wready = (st_r.wst != W_RESP) && !st_r.w_got;
	assign s_axi_bvalid = (st_r.wst == W_RESP);
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	// Pins
	assign pin_out = st_r.pin_out;
	assign pin_oe_n = st_r.pin_oe_n;
	assign scan_active = st_r.scan_on;

	// Enable write lands two edges after both channels taken
	a_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ1
		(s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == ADDR_W'(DRIVE_ENABLE_ADDR) && s_axi_wstrb[0])
		|=> ##1 st_r.drive_en == $past(s_axi_wdata[7:0], 2))
		else $error("enable write lost");
	// Signal pin driver follows its enable
	a_sig_drive: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ2
		st_r.drive_en[SIG_IN_BIT] |=> !pin_oe_n[SIG_IN_BIT])
		else $error("signal pin not driven");
	// Enabled clock pin shows its output bit
	a_clock_io: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ3
		st_r.drive_en[CLK_OUT_BIT] |=> pin_out[CLK_OUT_BIT] == $past(st_r.out_level[CLK_OUT_BIT]))
		else $error("clock pin not I/O");
	// Select pin drivers follow their enables
	a_select_drive: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ4
		1'b1 |=> pin_oe_n[SEL_UP_BIT:SEL_LO_BIT] == ~$past(st_r.drive_en[SEL_UP_BIT:SEL_LO_BIT]))
		else $error("select drive mismatch");
	// Unstrapped scan pins follow their enables
	a_scan_free: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ5
		!st_r.scan_on |=> pin_oe_n[3:0] == ~$past(st_r.drive_en[3:0]))
		else $error("scan pin drive mismatch");
	// Strapped scan pins stay with scan logic
	a_scan_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ6
		st_r.scan_on |=> pin_oe_n[3:0] == ~$past(scan_drive))
		else $error("strap not honoured");
	// Output register reaches every buffer that is plain I/O
	a_output_drive: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ7
		(!st_r.scan_on && (st_r.drive_en[CLK_OUT_BIT] || st_r.clk_sel == SEL_IO_CODE))
		|=> pin_out == $past(st_r.out_level))
		else $error("output level mismatch");
	// Output bit 2 lands on the TDI buffer
	a_tdi_level: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ8
		!st_r.scan_on |=> pin_out[TDI_BIT] == $past(st_r.out_level[TDI_BIT]))
		else $error("tdi level wrong");
	// Cleared enable leaves the pin released
	a_off_released: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ11
		!st_r.drive_en[SIG_IN_BIT] |=> pin_oe_n[SIG_IN_BIT])
		else $error("disabled pin driven");
	// Input register tracks the pins every cycle
	a_input_sample: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ11
		1'b1 |=> st_r.in_level == $past(pin_in))
		else $error("input level not sampled");
	// Input read returns the sampled levels
	a_input_read: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ9
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(INPUT_LEVEL_ADDR))
		|=> s_axi_rdata[7:0] == $past(st_r.in_level) && s_axi_rvalid)
		else $error("input read wrong");
	// Selector code 0 leaves the clock pin as I/O
	a_sel_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ10
		st_r.clk_sel == SEL_IO_CODE |=> pin_oe_n[CLK_OUT_BIT] == ~$past(st_r.drive_en[CLK_OUT_BIT]))
		else $error("code 0 not I/O");
	// Write to the input register changes nothing
	a_input_ro: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ12
		(st_r.wst == W_HAVE && st_r.aw_got && st_r.w_got
		&& st_r.waddr == ADDR_W'(INPUT_LEVEL_ADDR))
		|=> $stable(st_r.drive_en) && $stable(st_r.out_level))
		else $error("read-only write changed state");
	// Response follows the commit cycle
	a_write_answer: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ1
		(st_r.wst == W_HAVE && st_r.aw_got && st_r.w_got) |=> s_axi_bvalid)
		else $error("write response missing");
	// Read answer one cycle after the address is taken
	a_read_answer: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ9
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read answer missing");
	// Main scenarios reached
	c_write: cover property (@(posedge core_clk) disable iff (!rst_n) s_axi_bvalid && s_axi_bready);
	c_read: cover property (@(posedge core_clk) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);
	c_strap: cover property (@(posedge core_clk) disable iff (!rst_n) st_r.scan_on && |st_r.drive_en[3:0]);
	// Clock function shown on the clock pin
	c_clock_pin: cover property (@(posedge core_clk) disable iff (!rst_n)
		!st_r.drive_en[CLK_OUT_BIT] && st_r.clk_sel != SEL_IO_CODE && !pin_oe_n[CLK_OUT_BIT]);
endmodule // pin_io_config
`default_nettype wire

//--- tb/pin_world.sv
`default_nettype none
// Outside circuitry: a driven pin reads back its own level, a released one the board level
module pin_world (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Wire level per pin from both parties
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
		end
	end
endmodule // pin_world
`default_nettype wire

//--- tb/pin_io_config_test.sv
`default_nettype none
module pin_io_config_test;
	import pin_io_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, nrst = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [7:0] pin_in, pin_out, pin_oe_n, ext_level = 8'h3c;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, scan_active;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp;
	logic scan_strap = 0, clock_source = 0;
	logic [3:0] scan_out = 0, scan_drive = 0;
	int n_mismatch = 0, check_count = 0, wait_n;
	// Free-running core clock, 20 ns
	always #10 core_clk = ~core_clk;
	pin_io_config dut (.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.scan_strap(scan_strap), .scan_out(scan_out), .scan_drive(scan_drive),
		.clock_source(clock_source), .scan_active(scan_active));
	pin_world world (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
		.pin_in(pin_in));
	// Verdict and end of run
	task automatic final_report();
		$display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Bounded wait step
	task automatic tick();
		wait_n++;
		if (wait_n > 200) begin
			n_mismatch++;
			final_report();
		end
	endtask
	// One comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// AXI write, address and data offered together, response checked
	task automatic wc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh, ad, wd, bh;
		logic [1:0] r;
		{ad, wd, bh} = 3'b000;
		wait_n = 0;
		@(posedge core_clk);
		{awaddr, wdata} <= {a, d};
		{awvalid, wvalid, bready} <= 3'b111;
		while (!(ad && wd)) begin
			@(negedge core_clk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			@(posedge core_clk);
			tick();
			if (ah) begin
				awvalid <= 1'b0;
				ad = 1;
			end
			if (wh) begin
				wvalid <= 1'b0;
				wd = 1;
			end
		end
		while (!bh) begin
			@(negedge core_clk);
			{bh, r} = {bvalid, bresp};
			@(posedge core_clk);
			tick();
		end
		bready <= 1'b0;
		chk(r, er);
		repeat (3) @(posedge core_clk);
	endtask
	// AXI read, data and response checked
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic hit;
		logic [31:0] d;
		logic [1:0] r;
		hit = 0;
		wait_n = 0;
		@(posedge core_clk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		while (!hit) begin
			@(negedge core_clk);
			hit = arvalid && arready;
			@(posedge core_clk);
			tick();
		end
		arvalid <= 1'b0;
		hit = 0;
		while (!hit) begin
			@(negedge core_clk);
			{hit, d, r} = {rvalid, rdata, rresp};
			@(posedge core_clk);
			tick();
		end
		rready <= 1'b0;
		chk(d, e);
		chk(r, er);
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rc(DRIVE_ENABLE_ADDR, 0, RESP_OKAY);
		rc(OUTPUT_LEVEL_ADDR, 0, RESP_OKAY);
		chk(pin_oe_n, 8'hff);
		rc(INPUT_LEVEL_ADDR, 32'h3c, RESP_OKAY);
		rc(12'h140, 0, RESP_SLVERR);
		$display("Test reset and idle done");
		wc(OUTPUT_LEVEL_ADDR, 32'hffff_ffa5, RESP_OKAY);
		wc(DRIVE_ENABLE_ADDR, 32'h0000_00ff, RESP_OKAY);
		chk(pin_oe_n, 8'h00);
		chk(pin_out, 8'ha5);
		rc(DRIVE_ENABLE_ADDR, 32'hff, RESP_OKAY);
		rc(OUTPUT_LEVEL_ADDR, 32'ha5, RESP_OKAY);
		rc(INPUT_LEVEL_ADDR, 32'ha5, RESP_OKAY);
		wc(DRIVE_ENABLE_ADDR, 32'h30, RESP_OKAY);
		chk(pin_oe_n, 8'hcf);
		wc(DRIVE_ENABLE_ADDR, 32'h04, RESP_OKAY);
		chk(pin_oe_n, 8'hfb);
		rc(INPUT_LEVEL_ADDR, 32'h3c, RESP_OKAY);
		wc(INPUT_LEVEL_ADDR, 32'h00, RESP_OKAY);
		rc(INPUT_LEVEL_ADDR, 32'h3c, RESP_OKAY);
		$display("Test drive and levels done");
		wc(CLOCK_CTRL_ADDR, 32'h1, RESP_OKAY);
		rc(CLOCK_CTRL_ADDR, 32'h1, RESP_OKAY);
		clock_source <= 1'b1;
		wc(DRIVE_ENABLE_ADDR, 32'h00, RESP_OKAY);
		chk({pin_oe_n[6], pin_out[6]}, 2'b01);
		wc(DRIVE_ENABLE_ADDR, 32'h40, RESP_OKAY);
		chk({pin_oe_n[6], pin_out[6]}, 2'b00);
		wc(DRIVE_ENABLE_ADDR, 32'h00, RESP_OKAY);
		wc(CLOCK_CTRL_ADDR, 32'h0, RESP_OKAY);
		chk(pin_oe_n[6], 1'b1);
		$display("Test clock pin done");
		{scan_strap, scan_drive, scan_out} <= 9'h1a3;
		wc(DRIVE_ENABLE_ADDR, 32'h0f, RESP_OKAY);
		chk(pin_oe_n, 8'hf5);
		chk({scan_active, pin_out}, 9'h1a3);
		rc(CLOCK_CTRL_ADDR, 32'h10, RESP_OKAY);
		rc(DRIVE_ENABLE_ADDR, 32'h0f, RESP_OKAY);
		$display("Test scan strap done");
		final_report();
	end
endmodule // pin_io_config_test
`default_nettype wire
